// [design/acd_params.svh]
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH

// word addresses inside the constant RAM
`define ACD_ADDR_CALIB      4'h5
`define ACD_ADDR_LIMIT      4'h6
`define ACD_ADDR_CTRL_A     4'h7
`define ACD_ADDR_CTRL_B     4'h8

// reset values of the held words
`define ACD_RST_CALIB       16'h0000
`define ACD_RST_LIMIT       16'h0000
`define ACD_RST_CTRL_A      16'h4006
`define ACD_RST_CTRL_B      16'h0524
`define ACD_CTRL_B_MASK     16'h0fff

// thermal words
`define ACD_HI_BYTE_MSB     15
`define ACD_HI_BYTE_LSB     8
`define ACD_LO_BYTE_MSB     7
`define ACD_LO_BYTE_LSB     0
`define ACD_TEMP_OFFSET_C   9'h032

// control_word_a fields
`define ACD_A_ADC_MSB       15
`define ACD_A_ADC_LSB       14
`define ACD_A_LOCK          13
`define ACD_A_EXT_TB        12
`define ACD_A_EDGE          11
`define ACD_A_OCHK_MSB      10
`define ACD_A_OCHK_LSB      9
`define ACD_A_ICHK_MSB      8
`define ACD_A_ICHK_LSB      7
`define ACD_A_OSEL_MSB      6
`define ACD_A_OSEL_LSB      4
`define ACD_A_CHOP_MSB      3
`define ACD_A_CHOP_LSB      2
`define ACD_A_GAIN_MSB      1
`define ACD_A_GAIN_LSB      0

// control_word_b fields
`define ACD_B_ICHK_TOP      11
`define ACD_B_ZERO_FIX      10
`define ACD_B_AUTO_RET      9
`define ACD_B_TWATCH        8
`define ACD_B_TTALLY_MSB    7
`define ACD_B_TTALLY_LSB    6
`define ACD_B_OCHK_ON       5
`define ACD_B_OTALLY_MSB    4
`define ACD_B_OTALLY_LSB    3
`define ACD_B_ICHK_ON       2
`define ACD_B_ITALLY_MSB    1
`define ACD_B_ITALLY_LSB    0

// timing
`define ACD_CLK_NS          50
`define ACD_EDGE_FAST_NS    150
`define ACD_EDGE_SLOW_NS    750
`define ACD_EDGE_CYC(ns)    (((ns) + `ACD_CLK_NS - 1) / `ACD_CLK_NS)

`endif

// [design/acd_pkg.sv]
package acd_pkg;

    typedef enum logic [5:0] {
        ACD_OM_DIG     = 6'h01,
        ACD_OM_DIG_INV = 6'h02,
        ACD_OM_AN_P1   = 6'h04,
        ACD_OM_AN_P2   = 6'h08,
        ACD_OM_AN_P3   = 6'h10,
        ACD_OM_AN_STD  = 6'h20
    } acd_omode_e;

    typedef struct packed {
        logic [1:0]        cmd_adc_bits;
        logic              prog_lock;
        logic              ext_timebase;
        logic              edge_rate;
        logic [4:0]        edge_cycles;
        logic [3:0]        out_limit_pct;
        logic [2:0]        input_check_level;
        logic [12:0]       in_limit_uvv;
        acd_omode_e        out_mode;
        logic [1:0]        amp_chop_rate;
        logic [1:0]        amp_multiplier;
        logic              analog_zero_fix;
        logic              auto_return_cmd;
        logic              thermal_watch_on;
        logic              output_check_on;
        logic              input_check_on;
        logic [3:0]        thermal_depth;
        logic [3:0]        output_depth;
        logic [3:0]        input_depth;
        logic [7:0]        thermal_ref_level;
        logic [7:0]        thermal_zero_adj;
        logic signed [8:0] fault_limit_c;
        logic signed [8:0] alert_limit_c;
    } acd_dec_s;

endpackage : acd_pkg

// [design/acd_if.sv]
`timescale 1ns/1ps
interface acd_if;
    import acd_pkg::*;
    logic [15:0] calib;
    logic [15:0] limit;
    logic [15:0] ctrl_a;
    logic [15:0] ctrl_b;
    acd_dec_s    dec;

    modport regs (output calib, output limit, output ctrl_a, output ctrl_b, input dec);
    modport decd (input calib, input limit, input ctrl_a, input ctrl_b, output dec);
endinterface : acd_if

// [design/acd_decode.sv]
`timescale 1ns/1ps
`include "acd_params.svh"
module acd_decode
    import acd_pkg::*;
(
    acd_if.decd w
);

    function automatic logic [3:0] acd_tally(input logic [1:0] code);
        // 00/01/10/11 -> 0/2/4/8
        acd_tally = (code == 2'h0) ? 4'h0 : 4'(4'h1 << code);
    endfunction : acd_tally

    function automatic logic signed [8:0] acd_temp_c(input logic [7:0] code);
        acd_temp_c = $signed({1'b0, code}) - $signed(`ACD_TEMP_OFFSET_C);
    endfunction : acd_temp_c

    always_comb begin
        w.dec = '0;
        w.dec.thermal_ref_level = w.calib[`ACD_HI_BYTE_MSB:`ACD_HI_BYTE_LSB];
        w.dec.thermal_zero_adj  = w.calib[`ACD_LO_BYTE_MSB:`ACD_LO_BYTE_LSB];
        w.dec.fault_limit_c     =
            acd_temp_c(w.limit[`ACD_HI_BYTE_MSB:`ACD_HI_BYTE_LSB]);
        w.dec.alert_limit_c     =
            acd_temp_c(w.limit[`ACD_LO_BYTE_MSB:`ACD_LO_BYTE_LSB]);
        w.dec.cmd_adc_bits = w.ctrl_a[`ACD_A_ADC_MSB:`ACD_A_ADC_LSB];
        w.dec.prog_lock    = w.ctrl_a[`ACD_A_LOCK];
        w.dec.ext_timebase = w.ctrl_a[`ACD_A_EXT_TB];
        w.dec.edge_rate    = w.ctrl_a[`ACD_A_EDGE];
        w.dec.edge_cycles  = w.ctrl_a[`ACD_A_EDGE] ?
            5'(`ACD_EDGE_CYC(`ACD_EDGE_SLOW_NS)) :
            5'(`ACD_EDGE_CYC(`ACD_EDGE_FAST_NS));
        unique case (w.ctrl_a[`ACD_A_OCHK_MSB:`ACD_A_OCHK_LSB])
            2'h0: w.dec.out_limit_pct = 4'ha;
            2'h1: w.dec.out_limit_pct = 4'h5;
            2'h2: w.dec.out_limit_pct = 4'h2;
            2'h3: w.dec.out_limit_pct = 4'h1;
        endcase
        w.dec.input_check_level = {w.ctrl_b[`ACD_B_ICHK_TOP],
                                   w.ctrl_a[`ACD_A_ICHK_MSB:`ACD_A_ICHK_LSB]};
        case (w.dec.input_check_level)
            3'h1:    w.dec.in_limit_uvv = 13'h1860;
            3'h2:    w.dec.in_limit_uvv = 13'h1248;
            3'h3:    w.dec.in_limit_uvv = 13'h0c30;
            3'h4:    w.dec.in_limit_uvv = 13'h0618;
            // undefined codes fall back to the loosest limit
            default: w.dec.in_limit_uvv = 13'h1e78;
        endcase
        case (w.ctrl_a[`ACD_A_OSEL_MSB:`ACD_A_OSEL_LSB])
            3'h1:    w.dec.out_mode = ACD_OM_DIG_INV;
            3'h4:    w.dec.out_mode = ACD_OM_AN_P1;
            3'h5:    w.dec.out_mode = ACD_OM_AN_P2;
            3'h6:    w.dec.out_mode = ACD_OM_AN_P3;
            3'h7:    w.dec.out_mode = ACD_OM_AN_STD;
            default: w.dec.out_mode = ACD_OM_DIG;
        endcase
        w.dec.amp_chop_rate    = w.ctrl_a[`ACD_A_CHOP_MSB:`ACD_A_CHOP_LSB];
        w.dec.amp_multiplier   = w.ctrl_a[`ACD_A_GAIN_MSB:`ACD_A_GAIN_LSB];
        w.dec.analog_zero_fix  = w.ctrl_b[`ACD_B_ZERO_FIX];
        w.dec.auto_return_cmd  = w.ctrl_b[`ACD_B_AUTO_RET];
        w.dec.thermal_watch_on = w.ctrl_b[`ACD_B_TWATCH];
        w.dec.thermal_depth    =
            acd_tally(w.ctrl_b[`ACD_B_TTALLY_MSB:`ACD_B_TTALLY_LSB]);
        w.dec.output_check_on  = w.ctrl_b[`ACD_B_OCHK_ON];
        w.dec.output_depth     =
            acd_tally(w.ctrl_b[`ACD_B_OTALLY_MSB:`ACD_B_OTALLY_LSB]);
        w.dec.input_check_on   = w.ctrl_b[`ACD_B_ICHK_ON];
        w.dec.input_depth      =
            acd_tally(w.ctrl_b[`ACD_B_ITALLY_MSB:`ACD_B_ITALLY_LSB]);
    end

endmodule : acd_decode

// [design/acd_top.sv]
`timescale 1ns/1ps
`include "acd_params.svh"
// Function
// - temperature in Celsius is the unsigned byte code minus fifty
// - calibration word: reference level high byte, zero adjust low byte
// - limit word: fault limit high byte, alert limit low byte
// - command-mode conversion bits from word A bits 15:14, default 01
// - word A bit 13 is the programming lock, default zero
// - word A bit 12 selects external timebase, default zero
// - word A bit 11 picks 150 ns or 750 ns output edges
// - word A bits 10:9 give output limit 10, 5, 2, 1 percent
// - input check level: word B bit 11 over word A bits 8:7
// - word A bits 6:4 select digital, inverted or analog output modes
// - chopper rate from word A bits 3:2, default 01
// - amplifier gain from word A bits 1:0, default 10
// - word B bit 10 enables analog zero fix, default one
// - word B bit 9 enables automatic return to command mode
// - temperature supervision runs only while word B bit 8 is set
// - thermal error tally depth 0, 2, 4 or 8 from bits 7:6
// - output check runs only while word B bit 5 is set
// - output error tally depth 0, 2, 4 or 8 from bits 4:3
// - input check runs only while word B bit 2 is set
// - input error tally depth 0, 2, 4 or 8 from bits 1:0
// - programming ignored when lock was set at power-on load
module acd_top
    import acd_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // power-on load from nonvolatile store
    input  wire logic        ee_ld,
    input  wire logic [3:0]  ee_addr,
    input  wire logic [15:0] ee_data,
    input  wire logic        por_done,
    // constant RAM access from the command decoder
    input  wire logic        ram_wr,
    input  wire logic        ram_rd,
    input  wire logic [3:0]  ram_addr,
    input  wire logic [15:0] ram_wdata,
    output logic      [15:0] ram_rdata,
    output logic             ram_rvalid,
    // programming command
    input  wire logic        prog_req,
    output logic             prog_go,
    output logic             prog_locked,
    // temperature samples
    input  wire logic        temp_valid,
    input  wire logic [7:0]  temp_code,
    output logic             thermal_alert,
    output logic             thermal_fault,
    // decoded configuration
    output acd_dec_s         cfg
);

    typedef struct packed {
        logic [15:0] calib;
        logic [15:0] limit;
        logic [15:0] ctrl_a;
        logic [15:0] ctrl_b;
        logic        por_seen;
        logic        lock;
        logic        prog_go;
        logic [15:0] rdata;
        logic        rvalid;
        logic [3:0]  fault_cnt;
        logic [3:0]  alert_cnt;
        logic        fault;
        logic        alert;
        acd_dec_s    dec;
    } acd_state_s;

    acd_state_s state_reg;
    acd_state_s state_next;
    acd_if      w ();

    assign w.calib  = state_reg.calib;
    assign w.limit  = state_reg.limit;
    assign w.ctrl_a = state_reg.ctrl_a;
    assign w.ctrl_b = state_reg.ctrl_b;

    acd_decode u_decode (
        .w (w.decd)
    );

    // one write path shared by the power-on load and the command decoder
    function automatic acd_state_s acd_store(input acd_state_s s, input logic [3:0] a,
                                             input logic [15:0] d);
        acd_store = s;
        case (a)
            `ACD_ADDR_CALIB:  acd_store.calib  = d;
            `ACD_ADDR_LIMIT:  acd_store.limit  = d;
            `ACD_ADDR_CTRL_A: acd_store.ctrl_a = d;
            `ACD_ADDR_CTRL_B: acd_store.ctrl_b = d & `ACD_CTRL_B_MASK;
            default:          acd_store = s;
        endcase
    endfunction : acd_store

    function automatic logic [15:0] acd_fetch(input acd_state_s s, input logic [3:0] a);
        case (a)
            `ACD_ADDR_CALIB:  acd_fetch = s.calib;
            `ACD_ADDR_LIMIT:  acd_fetch = s.limit;
            `ACD_ADDR_CTRL_A: acd_fetch = s.ctrl_a;
            `ACD_ADDR_CTRL_B: acd_fetch = s.ctrl_b & `ACD_CTRL_B_MASK;
            default:          acd_fetch = 16'h0000;
        endcase
    endfunction : acd_fetch

    // consecutive-excess tally; depth 0 flags on the first excess
    function automatic logic [4:0] acd_tally_step(input logic [3:0] cnt, input logic over,
                                                  input logic [3:0] depth);
        logic [3:0] c;
        c = cnt;
        if (!over) begin
            acd_tally_step = 5'h00;
        end else begin
            if (c < depth) begin
                c = c + 4'h1;
            end
            acd_tally_step = {(c >= depth), c};
        end
    endfunction : acd_tally_step

    logic signed [8:0] temp_c;
    logic [4:0]        fault_step;
    logic [4:0]        alert_step;

    always_comb begin
        temp_c     = $signed({1'b0, temp_code}) - $signed(`ACD_TEMP_OFFSET_C);
        fault_step = acd_tally_step(state_reg.fault_cnt, temp_c > state_reg.dec.fault_limit_c,
                                    state_reg.dec.thermal_depth);
        alert_step = acd_tally_step(state_reg.alert_cnt, temp_c > state_reg.dec.alert_limit_c,
                                    state_reg.dec.thermal_depth);
        state_next         = state_reg;
        state_next.prog_go = 1'b0;
        state_next.rvalid  = 1'b0;
        state_next.dec     = w.dec;
        // load happens only before the power-on window closes
        if (ee_ld && !state_reg.por_seen) begin
            state_next = acd_store(state_next, ee_addr, ee_data);
        end
        if (ram_wr) begin
            state_next = acd_store(state_next, ram_addr, ram_wdata);
        end
        if (ram_rd) begin
            state_next.rdata  = acd_fetch(state_reg, ram_addr);
            state_next.rvalid = 1'b1;
        end
        // lock is frozen at the end of the power-on load, later RAM writes cannot lift it
        if (por_done && !state_reg.por_seen) begin
            state_next.por_seen = 1'b1;
            state_next.lock     = state_next.ctrl_a[`ACD_A_LOCK];
        end
        if (prog_req && state_reg.por_seen && !state_reg.lock) begin
            state_next.prog_go = 1'b1;
        end
        if (!state_reg.dec.thermal_watch_on) begin
            state_next.fault_cnt = 4'h0;
            state_next.alert_cnt = 4'h0;
            state_next.fault     = 1'b0;
            state_next.alert     = 1'b0;
        end else if (temp_valid) begin
            state_next.fault_cnt = fault_step[3:0];
            state_next.fault     = fault_step[4];
            state_next.alert_cnt = alert_step[3:0];
            state_next.alert     = alert_step[4];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg          <= '0;
            state_reg.calib    <= `ACD_RST_CALIB;
            state_reg.limit    <= `ACD_RST_LIMIT;
            state_reg.ctrl_a   <= `ACD_RST_CTRL_A;
            state_reg.ctrl_b   <= `ACD_RST_CTRL_B;
            state_reg.dec.out_mode <= ACD_OM_DIG;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ram_rdata     = state_reg.rdata;
    assign ram_rvalid    = state_reg.rvalid;
    assign prog_go       = state_reg.prog_go;
    assign prog_locked   = state_reg.lock;
    assign thermal_alert = state_reg.alert;
    assign thermal_fault = state_reg.fault;
    assign cfg           = state_reg.dec;

endmodule : acd_top

// [bench/acd_top_assertions.sv]
`timescale 1ns/1ps
`include "acd_params.svh"
module acd_top_assertions
    import acd_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // load and ram
    input wire logic        ee_ld,
    input wire logic [3:0]  ee_addr,
    input wire logic [15:0] ee_data,
    input wire logic        por_done,
    input wire logic        ram_wr,
    input wire logic        ram_rd,
    input wire logic [3:0]  ram_addr,
    input wire logic [15:0] ram_wdata,
    input wire logic [15:0] ram_rdata,
    input wire logic        ram_rvalid,
    // programming and temperature
    input wire logic        prog_req,
    input wire logic        prog_go,
    input wire logic        prog_locked,
    input wire logic        temp_valid,
    input wire logic [7:0]  temp_code,
    input wire logic        thermal_alert,
    input wire logic        thermal_fault,
    input wire acd_dec_s    cfg
);
    // cfg is only meaningful from the second edge after reset
    logic [1:0] up_reg;
    logic [1:0] up_next;
    always_comb begin
        up_next = (up_reg == 2'h2) ? up_reg : up_reg + 2'h1;
    end
    always_ff @(posedge mclk) begin
        up_reg <= rst ? 2'h0 : up_next;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    edge_time_a: assert property (
        up_reg == 2'h2 |-> cfg.edge_cycles == (cfg.edge_rate ? 5'h0f : 5'h03))
        else $error("edge cycles do not follow edge rate");
    out_limit_a: assert property (
        up_reg == 2'h2 |-> cfg.out_limit_pct inside {4'ha, 4'h5, 4'h2, 4'h1})
        else $error("output limit outside its table");
    in_limit_a: assert property (
        up_reg == 2'h2 && cfg.input_check_level == 3'h4 |-> cfg.in_limit_uvv == 13'h0618)
        else $error("input limit wrong for level four");
    mode_onehot_a: assert property ($onehot(cfg.out_mode))
        else $error("output mode not one-hot");
    tally_depth_a: assert property (
        cfg.thermal_depth inside {4'h0, 4'h2, 4'h4, 4'h8})
        else $error("thermal depth outside its table");
    prog_cause_a: assert property (
        prog_go |-> $past(prog_req) && !prog_locked)
        else $error("programming accepted without cause");
    lock_hold_a: assert property (
        !$past(por_done) |-> $stable(prog_locked))
        else $error("lock changed outside power-on load");
    read_answer_a: assert property (ram_rd |=> ram_rvalid)
        else $error("read not answered");
    upper_zero_a: assert property (
        ram_rvalid && $past(ram_addr) == `ACD_ADDR_CTRL_B |-> ram_rdata[15:12] == 4'h0)
        else $error("unused bits of word b read nonzero");
    fault_limit_a: assert property (
        ram_wr && ram_addr == `ACD_ADDR_LIMIT |-> ##2
        cfg.fault_limit_c == $signed({1'b0, $past(ram_wdata[15:8], 2)}) - 9'sh032)
        else $error("fault limit not decoded from write");
    alert_cause_a: assert property (
        $rose(thermal_alert) |-> $past(temp_valid && cfg.thermal_watch_on))
        else $error("alert without supervised sample");

    cover property (prog_go);
    cover property ($rose(thermal_fault));
    cover property (ram_rvalid && $past(ram_addr) == `ACD_ADDR_CTRL_B);
endmodule : acd_top_assertions

bind acd_top acd_top_assertions i_acd_top_assertions (.mclk, .rst, .ee_ld, .ee_addr,
    .ee_data, .por_done, .ram_wr, .ram_rd, .ram_addr, .ram_wdata, .ram_rdata, .ram_rvalid,
    .prog_req, .prog_go, .prog_locked, .temp_valid, .temp_code, .thermal_alert,
    .thermal_fault, .cfg);

// [bench/acd_ctrl_model.sv]
`timescale 1ns/1ps
module acd_ctrl_model (
    // clock
    input  wire logic        mclk,
    // load, ram and programming requests
    output logic             ee_ld,
    output logic [3:0]       ee_addr,
    output logic [15:0]      ee_data,
    output logic             por_done,
    output logic             ram_wr,
    output logic             ram_rd,
    output logic [3:0]       ram_addr,
    output logic [15:0]      ram_wdata,
    output logic             prog_req,
    // answers
    input  wire logic [15:0] ram_rdata,
    input  wire logic        ram_rvalid,
    input  wire logic        prog_go
);
    initial begin
        {ee_ld, por_done, ram_wr, ram_rd, prog_req} = 5'h00;
        {ee_addr, ram_addr} = 8'h00;
        {ee_data, ram_wdata} = 32'h0;
    end
    // released address and data show the inverse, never a stale copy
    task automatic load(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        ee_ld   <= 1'b1;
        ee_addr <= a;
        ee_data <= d;
        @(posedge mclk);
        ee_ld   <= 1'b0;
        ee_addr <= ~a;
        ee_data <= ~d;
    endtask : load
    task automatic finish();
        @(posedge mclk);
        por_done <= 1'b1;
        @(posedge mclk);
        por_done <= 1'b0;
    endtask : finish
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        ram_wr    <= 1'b1;
        ram_addr  <= a;
        ram_wdata <= d;
        @(posedge mclk);
        ram_wr    <= 1'b0;
        ram_addr  <= ~a;
        ram_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic v);
        @(posedge mclk);
        ram_rd   <= 1'b1;
        ram_addr <= a;
        @(posedge mclk);
        ram_rd   <= 1'b0;
        ram_addr <= ~a;
        #1;
        d = ram_rdata;
        v = ram_rvalid;
    endtask : rd
    task automatic prog(output logic g);
        @(posedge mclk);
        prog_req <= 1'b1;
        @(posedge mclk);
        prog_req <= 1'b0;
        #1;
        g = prog_go;
    endtask : prog
endmodule : acd_ctrl_model

// [bench/acd_top_tb.sv]
`timescale 1ns/1ps
module acd_top_tb
    import acd_pkg::*;
();
    logic        mclk, rst, ee_ld, por_done, ram_wr, ram_rd, ram_rvalid, prog_req;
    logic        prog_go, prog_locked, temp_valid, thermal_alert, thermal_fault;
    logic [3:0]  ee_addr, ram_addr;
    logic [15:0] ee_data, ram_wdata, ram_rdata;
    logic [7:0]  temp_code;
    acd_dec_s    cfg;
    int          fails = 0;
    int          check_count = 0;
    localparam logic [5:0]  OM[8]  = '{6'h01, 6'h02, 6'h01, 6'h01, 6'h04, 6'h08, 6'h10, 6'h20};
    localparam logic [3:0]  PCT[4] = '{4'ha, 4'h5, 4'h2, 4'h1};
    localparam logic [3:0]  DEP[4] = '{4'h0, 4'h2, 4'h4, 4'h8};
    localparam logic [12:0] UVV[8] = '{13'h1e78, 13'h1860, 13'h1248, 13'h0c30, 13'h0618,
                                      13'h1e78, 13'h1e78, 13'h1e78};

    acd_top i_acd_top (.mclk, .rst, .ee_ld, .ee_addr, .ee_data, .por_done, .ram_wr, .ram_rd,
        .ram_addr, .ram_wdata, .ram_rdata, .ram_rvalid, .prog_req, .prog_go, .prog_locked,
        .temp_valid, .temp_code, .thermal_alert, .thermal_fault, .cfg);
    acd_ctrl_model i_acd_ctrl_model (.mclk, .ee_ld, .ee_addr, .ee_data, .por_done, .ram_wr,
        .ram_rd, .ram_addr, .ram_wdata, .prog_req, .ram_rdata, .ram_rvalid, .prog_go);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdchk(input string n, input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        v;
        i_acd_ctrl_model.rd(a, d, v);
        chk("rvalid", 32'h1, v);
        chk(n, e, d);
    endtask : rdchk
    task automatic prog_try(input logic e);
        logic g;
        i_acd_ctrl_model.prog(g);
        chk("prog_go", e, g);
    endtask : prog_try
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle
    task automatic do_reset();
        @(posedge mclk) rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
    endtask : do_reset
    task automatic samp(input logic [7:0] c, input logic [1:0] e);
        @(posedge mclk);
        temp_valid <= 1'b1;
        temp_code  <= c;
        @(posedge mclk);
        temp_valid <= 1'b0;
        temp_code  <= ~c;
        @(posedge mclk);
        #1;
        chk("fault_alert", e, {thermal_fault, thermal_alert});
    endtask : samp

    task automatic t_defaults();
        rdchk("calib", 4'h5, 16'h0000);
        rdchk("limit", 4'h6, 16'h0000);
        rdchk("ctrl_a", 4'h7, 16'h4006);
        rdchk("ctrl_b", 4'h8, 16'h0524);
        i_acd_ctrl_model.wr(4'h3, 16'hbeef);
        rdchk("unmapped", 4'h3, 16'h0000);
    endtask : t_defaults
    task automatic t_fields();
        logic [2:0]  i;
        logic [15:0] a, b;
        for (int k = 0; k < 8; k++) begin
            i = 3'(k);
            a = {i[1:0], i[2], i[0], i[0], i[1:0], i[1:0], i, i[1:0], i[1:0]};
            b = {4'hf, i[2], i[0], i[1], i[0], i[1:0], i[1], i[1:0], i[0], i[1:0]};
            i_acd_ctrl_model.wr(4'h7, a);
            i_acd_ctrl_model.wr(4'h8, b);
            settle();
            rdchk("ctrl_a", 4'h7, a);
            rdchk("ctrl_b", 4'h8, {4'h0, b[11:0]});
            chk("adc", i[1:0], cfg.cmd_adc_bits);
            chk("lock_ext_edge", {i[2], i[0], i[0]},
                {cfg.prog_lock, cfg.ext_timebase, cfg.edge_rate});
            chk("edge_cycles", i[0] ? 32'h0000000f : 32'h00000003,
                cfg.edge_cycles);
            chk("out_limit", PCT[i[1:0]], cfg.out_limit_pct);
            chk("in_level", i, cfg.input_check_level);
            chk("in_limit", UVV[i], cfg.in_limit_uvv);
            chk("out_mode", OM[i], cfg.out_mode);
            chk("amp", {i[1:0], i[1:0]},
                {cfg.amp_chop_rate, cfg.amp_multiplier});
            chk("b_flags", {i[0], i[1], i[0], i[1], i[0]}, {cfg.analog_zero_fix,
                cfg.auto_return_cmd, cfg.thermal_watch_on, cfg.output_check_on,
                cfg.input_check_on});
            chk("depths", {3{DEP[i[1:0]]}}, {cfg.thermal_depth, cfg.output_depth,
                cfg.input_depth});
        end
    endtask : t_fields
    task automatic t_thermal();
        do_reset();
        i_acd_ctrl_model.wr(4'h8, 16'h0564);
        i_acd_ctrl_model.wr(4'h5, 16'ha53c);
        i_acd_ctrl_model.wr(4'h6, 16'h645a);
        settle();
        chk("calib", 16'ha53c, {cfg.thermal_ref_level, cfg.thermal_zero_adj});
        chk("fault_c", 9'sh032, cfg.fault_limit_c);
        chk("alert_c", 9'sh028, cfg.alert_limit_c);
        samp(8'h5a, 2'b00);
        samp(8'h5b, 2'b00);
        samp(8'h5b, 2'b01);
        samp(8'h65, 2'b01);
        samp(8'h65, 2'b11);
        samp(8'h10, 2'b00);
        samp(8'h65, 2'b00);
        samp(8'h65, 2'b11);
        // switching supervision off must drop flags that are standing
        i_acd_ctrl_model.wr(4'h8, 16'h0464);
        settle();
        chk("fault_alert_off", 2'b00, {thermal_fault, thermal_alert});
        samp(8'h65, 2'b00);
        samp(8'h65, 2'b00);
    endtask : t_thermal
    task automatic t_lock();
        for (int lk = 0; lk < 2; lk++) begin
            do_reset();
            prog_try(1'b0);
            i_acd_ctrl_model.load(4'h7, 16'h4006 | (16'(lk) << 13));
            i_acd_ctrl_model.finish();
            settle();
            chk("locked", lk, prog_locked);
            chk("lock_field", lk, cfg.prog_lock);
            prog_try(lk == 0);
            i_acd_ctrl_model.wr(4'h7, 16'h4006);
            prog_try(lk == 0);
        end
    endtask : t_lock

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #(50 * 3000);
        fails++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        temp_valid = 1'b0;
        temp_code = 8'h00;
        do_reset();
        t_defaults();
        t_fields();
        t_thermal();
        t_lock();
        test_done();
    end
endmodule : acd_top_tb
